// *** ctw_pkg.sv ***
package ctw_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_TRAP      = 8'h83;
  localparam logic [7:0] OP_WAIT      = 8'h8F;
  localparam logic [7:0] OP_ZCMP_DIR  = 8'h3D;
  localparam logic [7:0] OP_ZCMP_A    = 8'h4D;
  localparam logic [7:0] OP_ZCMP_X    = 8'h5D;
  localparam logic [7:0] OP_ZCMP_IX1  = 8'h6D;
  localparam logic [7:0] OP_ZCMP_IX   = 8'h7D;
  localparam logic [7:0] OP_ZCMP_STK  = 8'h6D;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_TRAP     = 4'h9;
  localparam logic [3:0] CYC_WAIT     = 4'h1;
  localparam logic [3:0] CYC_ZCMP_DIR = 4'h3;
  localparam logic [3:0] CYC_ZCMP_IMP = 4'h1;
  localparam logic [3:0] CYC_ZCMP_IX1 = 4'h3;
  localparam logic [3:0] CYC_ZCMP_IX  = 4'h2;
  localparam logic [3:0] CYC_ZCMP_STK = 4'h4;

  // ----------------------------------------------------------------
  // Trap sequence steps
  // ----------------------------------------------------------------
  localparam logic [3:0] STP_PUSH_PLO = 4'h1;
  localparam logic [3:0] STP_PUSH_PHI = 4'h2;
  localparam logic [3:0] STP_PUSH_X   = 4'h3;
  localparam logic [3:0] STP_PUSH_A   = 4'h4;
  localparam logic [3:0] STP_PUSH_FLG = 4'h5;
  localparam logic [3:0] STP_SET_MASK = 4'h6;
  localparam logic [3:0] STP_VEC_HI   = 4'h7;
  localparam logic [3:0] STP_VEC_LO   = 4'h8;

  // ----------------------------------------------------------------
  // Condition flag bit positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_V = 7;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [7:0]  ZERO_PAGE = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] stack_ptr;
    logic [15:0] hx;
    logic [7:0]  a;
    logic [7:0]  flags;
  } ctw_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ctw_mem_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} ctw_state_t;

endpackage

// *** ctw_core.sv ***
`timescale 1ns/100ps
// How it works
// - Trap runs nine cycles; vector high, then low byte, loads counter.
// - Trap: counter+1; push low, high counter, X, A, flags; set mask.
// - Wait runs one cycle, clears mask, other flags untouched.
// - After wait the core halts its clocking until an interrupt arrives.
// - Zero compare of A, X or memory: V cleared, N and Z updated.
module ctw_core
  import ctw_pkg::*;
#(
  parameter logic [15:0] VEC_ADDR = 16'hFFFC
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  // Instruction issue
  input  wire logic       start_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic       prefix_in,
  input  wire logic [7:0] operand_in,
  input  wire ctw_regs_t  regs_in,
  // Completion
  output logic            busy_out,
  output logic            done_out,
  output ctw_regs_t       regs_out,
  // Interrupt and clock gating
  input  wire logic       irq_in,
  output logic            cpu_run_out,
  // Internal memory bus
  output ctw_mem_t        mem_out,
  input  wire logic [7:0] mem_rdata_in
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] op_cycles(input logic [7:0] op,
                                           input logic       pre);
    logic [3:0] c;
    c = 4'h0;
    if (pre) begin
      // Only the stack-offset zero compare follows the prefix
      if (op == OP_ZCMP_STK) c = CYC_ZCMP_STK;
    end else begin
      case (op)
        OP_TRAP:     c = CYC_TRAP;
        OP_WAIT:     c = CYC_WAIT;
        OP_ZCMP_DIR: c = CYC_ZCMP_DIR;
        OP_ZCMP_A:   c = CYC_ZCMP_IMP;
        OP_ZCMP_X:   c = CYC_ZCMP_IMP;
        OP_ZCMP_IX1: c = CYC_ZCMP_IX1;
        OP_ZCMP_IX:  c = CYC_ZCMP_IX;
        default:     c = 4'h0;
      endcase
    end
    return c;
  endfunction

  ctw_state_t  state_r;
  ctw_state_t  state_nxt;
  ctw_regs_t   work_r;
  ctw_regs_t   work_nxt;
  logic [7:0]  op_r;
  logic        pre_r;
  logic [7:0]  opd_r;
  logic [3:0]  step_r;
  logic [3:0]  total_r;
  logic        done_r;

  wire logic [3:0] start_cyc = op_cycles(opcode_in, prefix_in);
  wire logic       accept    = (state_r == ST_IDLE) && start_in
                               && (start_cyc != 4'h0);
  wire logic       last      = (state_r == ST_EXEC)
                               && (step_r == total_r - 4'h1);
  wire logic       is_trap   = !pre_r && (op_r == OP_TRAP);
  wire logic       is_wait   = !pre_r && (op_r == OP_WAIT);
  wire logic       is_zcmp_a = !pre_r && (op_r == OP_ZCMP_A);
  wire logic       is_zcmp_x = !pre_r && (op_r == OP_ZCMP_X);
  // Anything not trap, wait or register compare reads memory
  wire logic       is_zcmp_m = !is_trap && !is_wait && !is_zcmp_a
                               && !is_zcmp_x;

  // ----------------------------------------------------------------
  // Test operand address
  // ----------------------------------------------------------------
  wire logic [15:0] zcmp_addr =
      pre_r                 ? work_r.stack_ptr + {8'h00, opd_r} :
      (op_r == OP_ZCMP_DIR) ? {ZERO_PAGE, opd_r} :
      (op_r == OP_ZCMP_IX1) ? work_r.hx + {8'h00, opd_r} :
                              work_r.hx;

  // ----------------------------------------------------------------
  // Trap push data select
  // ----------------------------------------------------------------
  wire logic [7:0] push_data =
      (step_r == STP_PUSH_PLO) ? work_r.pc[7:0]  :
      (step_r == STP_PUSH_PHI) ? work_r.pc[15:8] :
      (step_r == STP_PUSH_X)   ? work_r.hx[7:0]  :
      (step_r == STP_PUSH_A)   ? work_r.a        :
                                 work_r.flags;

  // Pushes fall on steps one to five, one byte per cycle
  wire logic trap_push = (state_r == ST_EXEC) && is_trap
                         && (step_r >= STP_PUSH_PLO)
                         && (step_r <= STP_PUSH_FLG);
  wire logic trap_vhi  = (state_r == ST_EXEC) && is_trap
                         && (step_r == STP_VEC_HI);
  wire logic trap_vlo  = (state_r == ST_EXEC) && is_trap
                         && (step_r == STP_VEC_LO);
  wire logic zcmp_rd   = last && is_zcmp_m;

  // ----------------------------------------------------------------
  // Memory bus
  // ----------------------------------------------------------------
  // Strobes last one cycle; read data is taken in that same cycle
  assign mem_out.wr    = trap_push;
  assign mem_out.rd    = trap_vhi || trap_vlo || zcmp_rd;
  assign mem_out.wdata = trap_push ? push_data : RST_BYTE;
  assign mem_out.addr  = trap_push ? work_r.stack_ptr :
                         trap_vhi  ? VEC_ADDR :
                         trap_vlo  ? VEC_ADDR + 16'h0001 :
                         zcmp_rd   ? zcmp_addr : RST_WORD;

  wire logic [7:0] zcmp_val = is_zcmp_a ? work_r.a :
                              is_zcmp_x ? work_r.hx[7:0] : mem_rdata_in;

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  always_comb begin
    work_nxt = work_r;
    if (accept) begin
      work_nxt = regs_in;
    end else if (state_r == ST_EXEC) begin
      if (is_trap) begin
        if (step_r == 4'h0) begin
          work_nxt.pc = work_r.pc + 16'h0001;
        end
        if (trap_push) begin
          work_nxt.stack_ptr = work_r.stack_ptr - 16'h0001;
        end
        if (step_r == STP_SET_MASK) begin
          work_nxt.flags[FLG_I] = 1'b1;
        end
        if (trap_vhi) begin
          work_nxt.pc[15:8] = mem_rdata_in;
        end
        if (trap_vlo) begin
          work_nxt.pc[7:0] = mem_rdata_in;
        end
      end else if (is_wait) begin
        // Wait only drops the mask; the halt follows in the state machine
        work_nxt.flags[FLG_I] = 1'b0;
      end else if (last) begin
        work_nxt.flags[FLG_V] = 1'b0;
        work_nxt.flags[FLG_N] = zcmp_val[7];
        work_nxt.flags[FLG_Z] = (zcmp_val == 8'h00);
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        if (last) state_nxt = is_wait ? ST_HALT : ST_IDLE;
      end
      ST_HALT: begin
        // Every register except done_r holds still until irq_in wakes the core
        if (irq_in) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      work_r  <= '0;
      op_r    <= RST_BYTE;
      pre_r   <= 1'b0;
      opd_r   <= RST_BYTE;
      step_r  <= 4'h0;
      total_r <= 4'h0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      work_r  <= work_nxt;
      done_r  <= last;
      if (accept) begin
        op_r    <= opcode_in;
        pre_r   <= prefix_in;
        opd_r   <= operand_in;
        total_r <= start_cyc;
        step_r  <= 4'h0;
      end else if (state_r == ST_EXEC) begin
        step_r <= step_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy_out    = (state_r != ST_IDLE);
  assign done_out    = done_r;
  assign regs_out    = work_r;
  assign cpu_run_out = (state_r != ST_HALT);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The low vector byte sits one above VEC_ADDR, so the pair must not
  // wrap past the top of the address space.
  if (VEC_ADDR == 16'hFFFF) begin : g_vec_check
    $error("VEC_ADDR leaves no room for the low vector byte");
  end

endmodule

// *** ctw_mem_model.sv ***
`timescale 1ns/100ps
module ctw_mem_model
  import ctw_pkg::*;
(
  // Bus
  input  wire logic     clock_in,
  input  wire ctw_mem_t mem_in,
  output logic [7:0]    rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'hA5;
  // Undriven read data flips so stale bytes never look valid
  assign rdata_out = mem_in.rd ? mem[mem_in.addr] : ~last_r;
  always @(posedge clock_in) begin
    if (mem_in.wr)
      mem[mem_in.addr] <= mem_in.wdata;
    if (mem_in.rd)
      last_r <= mem[mem_in.addr];
  end
endmodule

// *** ctw_core_properties.sv ***
`timescale 1ns/100ps
module ctw_chk
  import ctw_pkg::*;
#(
  parameter logic [15:0] VEC_ADDR = 16'hFFFC
) (
  // Watched ports
  input wire logic       clock_in,
  input wire logic       srst_in,
  input wire logic       start_in,
  input wire logic [7:0] opcode_in,
  input wire logic       prefix_in,
  input wire ctw_regs_t  regs_in,
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire ctw_regs_t  regs_out,
  input wire logic       irq_in,
  input wire logic       cpu_run_out,
  input wire ctw_mem_t   mem_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  wire logic acc = start_in && !busy_out && !prefix_in;
  wire logic tr  = acc && opcode_in == OP_TRAP;
  wire logic wt  = acc && opcode_in == OP_WAIT;
  wire logic ta  = acc && opcode_in == OP_ZCMP_A;
  sequence s_vec;
    mem_out.rd && mem_out.addr == VEC_ADDR
    ##1 mem_out.rd && mem_out.addr == VEC_ADDR + 16'h0001;
  endsequence
  a_trap_nine: assert property (tr |-> ##9 busy_out
    ##1 (done_out && !busy_out))
    else $error("trap length wrong");
  a_trap_vector: assert property (tr |-> ##8 s_vec ##1 done_out)
    else $error("vector fetch wrong");
  a_trap_push: assert property (tr |-> ##2 mem_out.wr
    && mem_out.addr == $past(regs_in.stack_ptr, 2)
    && mem_out.wdata == $past(regs_in.pc[7:0], 2) + 8'h01)
    else $error("first push wrong");
  a_wait_clear: assert property (wt |-> ##2 done_out
    && !regs_out.flags[FLG_I] && !cpu_run_out
    && regs_out.flags[7:4] == $past(regs_in.flags[7:4], 2)
    && regs_out.flags[2:0] == $past(regs_in.flags[2:0], 2))
    else $error("wait flags wrong");
  a_halt_hold: assert property (!cpu_run_out
    |=> cpu_run_out == $past(irq_in))
    else $error("halt exit wrong");
  a_zcmp_acc: assert property (ta |-> ##2 done_out
    && !regs_out.flags[FLG_V]
    && regs_out.flags[FLG_N] == $past(regs_in.a[7], 2)
    && regs_out.flags[FLG_Z] == ($past(regs_in.a, 2) == 8'h00)
    && regs_out.flags[4:3] == $past(regs_in.flags[4:3], 2)
    && regs_out.flags[0] == $past(regs_in.flags[0], 2))
    else $error("compare flags wrong");
endmodule
bind ctw_core ctw_chk #(.VEC_ADDR(VEC_ADDR)) u_chk (
  .clock_in(clock_in), .srst_in(srst_in), .start_in(start_in),
  .opcode_in(opcode_in), .prefix_in(prefix_in), .regs_in(regs_in),
  .busy_out(busy_out), .done_out(done_out), .regs_out(regs_out),
  .irq_in(irq_in), .cpu_run_out(cpu_run_out), .mem_out(mem_out));

// *** cpu_trap_wait_test_ops_tb.sv ***
`timescale 1ns/100ps
module cpu_trap_wait_test_ops_tb;
  import ctw_pkg::*;
  logic       clock_in, srst_in, start_in, prefix_in, irq_in;
  logic [7:0] opcode_in, operand_in, mem_rdata_in;
  logic       busy_out, done_out, cpu_run_out;
  ctw_regs_t  regs_in, regs_out;
  ctw_mem_t   mem_out;
  int         fail_count, num_checks;
  ctw_core uut (.clock_in(clock_in), .srst_in(srst_in),
    .start_in(start_in), .opcode_in(opcode_in), .prefix_in(prefix_in),
    .operand_in(operand_in), .regs_in(regs_in), .busy_out(busy_out),
    .done_out(done_out), .regs_out(regs_out), .irq_in(irq_in),
    .cpu_run_out(cpu_run_out), .mem_out(mem_out),
    .mem_rdata_in(mem_rdata_in));
  ctw_mem_model mdl (.clock_in(clock_in), .mem_in(mem_out),
    .rdata_out(mem_rdata_in));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Issue one opcode and time its completion
  // ----
  task automatic run(logic [7:0] op, logic p, logic [7:0] d,
                     ctw_regs_t r, int n);
    int k;
    k = 0;
    @(posedge clock_in);
    start_in <= 1'b1;
    opcode_in <= op;
    prefix_in <= p;
    operand_in <= d;
    regs_in <= r;
    @(posedge clock_in);
    start_in <= 1'b0;
    while (done_out !== 1'b1 && k < 20) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    if (k == 20) begin
      fail_count++;
      final_report;
    end else begin
      check("cycles", k, n);
    end
  endtask
  task automatic t_trap;
    run(OP_TRAP, 1'b0, 8'h00, '{16'h1234, 16'h00FF, 16'h0056,
        8'h78, 8'h85}, 9);
    check("push", {mdl.mem[16'h00FF], mdl.mem[16'h00FE],
      mdl.mem[16'h00FD], mdl.mem[16'h00FC]}, 32'h35125678);
    check("push flags", mdl.mem[16'h00FB], 8'h85);
    check("pc", regs_out.pc, 16'hABCD);
    check("stack flags", {regs_out.stack_ptr, regs_out.flags},
          24'h00FA8D);
  endtask
  task automatic t_wait;
    run(OP_WAIT, 1'b0, 8'h00, '{16'h0100, 16'h00FF, 16'h0000,
        8'h00, 8'hFF}, 1);
    check("flags", regs_out.flags, 8'hF7);
    repeat (4) @(posedge clock_in);
    #1;
    check("halt", {cpu_run_out, busy_out}, 2'b01);
    @(posedge clock_in);
    irq_in <= 1'b1;
    @(posedge clock_in);
    irq_in <= 1'b0;
    #1;
    check("resume", {cpu_run_out, busy_out}, 2'b10);
  endtask
  task automatic t_zcmp;
    logic [7:0] op [6] = '{OP_ZCMP_DIR, OP_ZCMP_A, OP_ZCMP_X,
                           OP_ZCMP_IX1, OP_ZCMP_IX, OP_ZCMP_STK};
    logic [7:0] d  [6] = '{8'h40, 8'h00, 8'h00, 8'h10, 8'h00, 8'h05};
    logic [7:0] ex [6] = '{8'h1D, 8'h1B, 8'h1D, 8'h1B, 8'h19, 8'h1B};
    int         cy [6] = '{3, 1, 1, 3, 2, 4};
    for (int i = 0; i < 6; i++) begin
      run(op[i], i == 5, d[i], '{16'h0000, 16'h0200, 16'h0180,
          8'h00, 8'h99}, cy[i]);
      check("zcmp flags", regs_out.flags, ex[i]);
    end
  endtask
  // ----
  // Cut a trap by reset, then run one compare straight after release
  // ----
  task automatic t_reset;
    @(posedge clock_in);
    start_in <= 1'b1;
    opcode_in <= OP_TRAP;
    prefix_in <= 1'b0;
    regs_in <= '{16'h1234, 16'h00FF, 16'h0056, 8'h78, 8'h85};
    @(posedge clock_in);
    start_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    #1;
    check("rst ctl", {busy_out, done_out, cpu_run_out, mem_out.wr,
          mem_out.rd}, 5'b00100);
    check("rst regs", {regs_out.pc, regs_out.stack_ptr}, 32'h0);
    run(OP_ZCMP_A, 1'b0, 8'h00, '{16'h0000, 16'h0000, 16'h0000,
        8'h00, 8'h00}, 1);
    check("rst flags", regs_out.flags, 8'h02);
  endtask
  initial begin
    srst_in = 1'b1;
    start_in = 1'b0;
    prefix_in = 1'b0;
    irq_in = 1'b0;
    opcode_in = 8'h00;
    operand_in = 8'h00;
    regs_in = '0;
    fail_count = 0;
    num_checks = 0;
    mdl.mem[16'hFFFC] = 8'hAB;
    mdl.mem[16'hFFFD] = 8'hCD;
    mdl.mem[16'h0040] = 8'h80;
    mdl.mem[16'h0190] = 8'h00;
    mdl.mem[16'h0180] = 8'h7F;
    mdl.mem[16'h0205] = 8'h00;
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    t_trap;
    t_wait;
    t_zcmp;
    t_reset;
    final_report;
  end
endmodule
